// ### inc/fesq_map.svh
`ifndef FESQ_MAP_SVH
`define FESQ_MAP_SVH

// ====================================================================
// software register offsets
`define FESQ_REG_CMD   5'h00
`define FESQ_REG_ADDR  5'h04
`define FESQ_REG_DATA  5'h08
`define FESQ_REG_COUNT 5'h0C
`define FESQ_REG_BUF   5'h10
`define FESQ_REG_STAT  5'h14
`define FESQ_REG_CTRL  5'h18

// ====================================================================
// flash command codes
`define FESQ_CMD_ERASE_SETUP 8'h20
`define FESQ_CMD_CHIP_SETUP  8'h30
`define FESQ_CMD_PROG_SETUP  8'h40
`define FESQ_CMD_PROG_ALT    8'h10
`define FESQ_CMD_BUF_SETUP   8'hE8
`define FESQ_CMD_CONFIRM     8'hD0
`define FESQ_CMD_CLR_STATUS  8'h50

// ====================================================================
// bit positions and buffer depth
`define FESQ_SR_READY      7
`define FESQ_SR_ERASE_ERR  5
`define FESQ_SR_PROG_ERR   4
`define FESQ_XSR_BUF_AVAIL 7
`define FESQ_ST_DONE       16
`define FESQ_ST_REFUSED    17
`define FESQ_ST_STS        18
`define FESQ_ST_BUSY       19
`define FESQ_CTRL_WP       0
`define FESQ_CTRL_ALT      1
`define FESQ_BUF_WORDS     16

// ====================================================================
// bus timing
`define FESQ_CLK_NS      20
`define FESQ_T_WSETUP_NS 20
`define FESQ_T_WP_NS     60
`define FESQ_T_WREC_NS   40
`define FESQ_T_ACC_NS    100
`define FESQ_SYNC_CYC    2
`define FESQ_WSETUP_CYC  ((`FESQ_T_WSETUP_NS + `FESQ_CLK_NS - 1) / `FESQ_CLK_NS)
`define FESQ_WP_CYC      ((`FESQ_T_WP_NS + `FESQ_CLK_NS - 1) / `FESQ_CLK_NS)
`define FESQ_WREC_CYC    ((`FESQ_T_WREC_NS + `FESQ_CLK_NS - 1) / `FESQ_CLK_NS)
`define FESQ_RD_CYC      ((`FESQ_T_ACC_NS + `FESQ_CLK_NS - 1) / `FESQ_CLK_NS + `FESQ_SYNC_CYC)

`endif

// ### inc/fesq_pkg.sv
package fesq_pkg;
  typedef enum logic [2:0] {
    FESQ_OP_NONE, FESQ_OP_ERASE_BLK, FESQ_OP_ERASE_CHIP, FESQ_OP_PROG, FESQ_OP_BUF, FESQ_OP_CLR
  } fesq_op_e;
  typedef enum logic [3:0] {
    S_IDLE, S_W1, S_W2, S_XSET, S_XRD, S_CNT, S_LOAD, S_CONF, S_POLL
  } fesq_st_e;
  typedef enum logic [2:0] {
    B_IDLE, B_WSET, B_WPUL, B_WREC, B_RACC
  } fesq_bst_e;
  typedef logic [15:0] fesq_word_t;
endpackage : fesq_pkg

// ### inc/fesq_if.sv
`timescale 1ns/100ps
interface fesq_if;
  logic        req;
  logic        wr;
  logic [20:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;
  modport mst (output req, wr, addr, wdata, input rdata, ack);
  modport slv (input req, wr, addr, wdata, output rdata, ack);
endinterface : fesq_if

// ### logic/fesq_bus.sv
`timescale 1ns/100ps
`include "fesq_map.svh"
module fesq_bus import fesq_pkg::*; (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // cycle requests
  fesq_if.slv              bus,
  // flash pins
  output logic      [20:0] o_fl_addr,
  input  wire logic [15:0] i_fl_dq,
  output logic      [15:0] o_fl_dq,
  output logic             o_fl_dq_oe,
  output logic             o_fl_ce_n,
  output logic             o_fl_we_n,
  output logic             o_fl_oe_n
);
  // ==================================================================
  // state
  fesq_bst_e  st_q;
  logic [2:0] cnt_q;
  fesq_word_t dq_m_q;
  fesq_word_t dq_s_q;
  fesq_word_t rdata_q;
  logic       ack_q;
  wire        cnt_zero = (cnt_q == 3'h0);

  assign bus.rdata = rdata_q;
  assign bus.ack   = ack_q;

  // ==================================================================
  // pin data synchroniser, read access covers its two stages
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      dq_m_q <= 16'h0000;
      dq_s_q <= 16'h0000;
    end else begin
      dq_m_q <= i_fl_dq;
      dq_s_q <= dq_m_q;
    end
  end

  // ==================================================================
  // write and read cycle sequencer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q       <= B_IDLE;
      cnt_q      <= 3'h0;
      ack_q      <= 1'b0;
      rdata_q    <= 16'h0000;
      o_fl_addr  <= 21'h000000;
      o_fl_dq    <= 16'h0000;
      o_fl_dq_oe <= 1'b0;
      o_fl_ce_n  <= 1'b1;
      o_fl_we_n  <= 1'b1;
      o_fl_oe_n  <= 1'b1;
    end else begin
      ack_q <= 1'b0;
      case (st_q)
        B_IDLE: begin
          if (bus.req) begin
            o_fl_addr <= bus.addr;
            o_fl_dq   <= bus.wdata;
            o_fl_ce_n <= 1'b0;
            if (bus.wr) begin
              o_fl_dq_oe <= 1'b1;
              cnt_q      <= 3'(`FESQ_WSETUP_CYC - 1);
              st_q       <= B_WSET;
            end else begin
              o_fl_oe_n <= 1'b0;
              cnt_q     <= 3'(`FESQ_RD_CYC - 1);
              st_q      <= B_RACC;
            end
          end
        end
        B_WSET: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_zero) begin
            o_fl_we_n <= 1'b0;
            cnt_q     <= 3'(`FESQ_WP_CYC - 1);
            st_q      <= B_WPUL;
          end
        end
        B_WPUL: begin
          // address and data are taken by the flash on this rising edge
          cnt_q <= cnt_q - 3'h1;
          if (cnt_zero) begin
            o_fl_we_n <= 1'b1;
            cnt_q     <= 3'(`FESQ_WREC_CYC - 1);
            st_q      <= B_WREC;
          end
        end
        B_WREC: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_zero) begin
            o_fl_ce_n  <= 1'b1;
            o_fl_dq_oe <= 1'b0;
            ack_q      <= 1'b1;
            st_q       <= B_IDLE;
          end
        end
        B_RACC: begin
          cnt_q <= cnt_q - 3'h1;
          if (cnt_zero) begin
            rdata_q   <= dq_s_q;
            o_fl_oe_n <= 1'b1;
            o_fl_ce_n <= 1'b1;
            ack_q     <= 1'b1;
            st_q      <= B_IDLE;
          end
        end
        default: st_q <= B_IDLE;
      endcase
    end
  end
endmodule : fesq_bus

// ### logic/fesq_host.sv
`timescale 1ns/100ps
`include "fesq_map.svh"
module fesq_host import fesq_pkg::*; (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // software port
  input  wire logic [4:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // flash pins
  output logic      [20:0] o_fl_addr,
  input  wire logic [15:0] i_fl_dq,
  output logic      [15:0] o_fl_dq,
  output logic             o_fl_dq_oe,
  output logic             o_fl_ce_n,
  output logic             o_fl_we_n,
  output logic             o_fl_oe_n,
  output logic             o_fl_wp_n,
  input  wire logic        i_fl_sts
);
  // ==================================================================
  // state
  fesq_st_e   st_q;
  fesq_op_e   op_q;
  logic [20:0] addr_q;
  fesq_word_t data_q;
  logic [3:0] cnt_q;
  fesq_word_t buf_q [`FESQ_BUF_WORDS];
  logic [3:0] bptr_q;
  logic [3:0] idx_q;
  logic       issued_q;
  logic [7:0] fsr_q;
  logic [7:0] xsr_q;
  logic [7:0] retry_q;
  logic [1:0] ctrl_q;
  logic       done_q;
  logic       refused_q;
  logic       sts_m_q;
  logic       sts_s_q;

  fesq_if u_bus_if ();

  // ==================================================================
  // software decode
  wire       busy      = (st_q != S_IDLE);
  wire       wr_cmd    = i_wr && (i_addr == `FESQ_REG_CMD);
  wire       wr_cfg    = i_wr && !busy;
  wire       wr_stat   = i_wr && (i_addr == `FESQ_REG_STAT);
  fesq_op_e  op_in;
  assign op_in = fesq_op_e'(i_wdata[2:0]);
  wire       op_ok     = (op_in != FESQ_OP_NONE) && (i_wdata[2:0] <= 3'(FESQ_OP_CLR));
  wire       err_set   = fsr_q[`FESQ_SR_PROG_ERR] || fsr_q[`FESQ_SR_ERASE_ERR];
  wire       start     = wr_cmd && !busy && op_ok;
  wire       refuse    = start && (op_in == FESQ_OP_BUF) && err_set;
  wire [31:0] stat_word = {12'h000, busy, sts_s_q, refused_q, done_q, xsr_q, fsr_q};
  wire [31:0] rd_mux =
    (i_addr == `FESQ_REG_CMD)   ? {28'h0000000, busy, op_q} :
    (i_addr == `FESQ_REG_ADDR)  ? {11'h000, addr_q} :
    (i_addr == `FESQ_REG_DATA)  ? {16'h0000, data_q} :
    (i_addr == `FESQ_REG_COUNT) ? {16'h0000, retry_q, 4'h0, cnt_q} :
    (i_addr == `FESQ_REG_BUF)   ? {28'h0000000, bptr_q} :
    (i_addr == `FESQ_REG_STAT)  ? stat_word :
    (i_addr == `FESQ_REG_CTRL)  ? {30'h00000000, ctrl_q} : 32'h00000000;

  // ==================================================================
  // flash bus request selection
  wire       bus_state = busy;
  wire       bus_req   = bus_state && !issued_q;
  wire       bus_wr    = (st_q != S_XRD) && (st_q != S_POLL);
  wire       bus_ack   = u_bus_if.ack;
  wire [15:0] bus_rdata = u_bus_if.rdata;
  wire [7:0] prog_code = ctrl_q[`FESQ_CTRL_ALT] ? `FESQ_CMD_PROG_ALT : `FESQ_CMD_PROG_SETUP;
  wire [7:0] setup_code =
    (op_q == FESQ_OP_ERASE_BLK)  ? `FESQ_CMD_ERASE_SETUP :
    (op_q == FESQ_OP_ERASE_CHIP) ? `FESQ_CMD_CHIP_SETUP :
    (op_q == FESQ_OP_PROG)       ? prog_code : `FESQ_CMD_CLR_STATUS;
  wire [20:0] bus_addr = (st_q == S_LOAD) ? addr_q + {17'h00000, idx_q} : addr_q;
  wire [15:0] bus_wdata =
    (st_q == S_W1)                            ? {8'h00, setup_code} :
    (st_q == S_W2 && op_q == FESQ_OP_PROG)    ? data_q :
    (st_q == S_XSET)                          ? {8'h00, `FESQ_CMD_BUF_SETUP} :
    (st_q == S_CNT)                           ? {12'h000, cnt_q} :
    (st_q == S_LOAD)                          ? buf_q[idx_q] : {8'h00, `FESQ_CMD_CONFIRM};
  wire       poll_ok   = (st_q == S_POLL) && bus_ack && bus_rdata[`FESQ_SR_READY];
  wire       set_done  = poll_ok || (st_q == S_W1 && bus_ack && op_q == FESQ_OP_CLR);

  assign u_bus_if.req   = bus_req;
  assign u_bus_if.wr    = bus_wr;
  assign u_bus_if.addr  = bus_addr;
  assign u_bus_if.wdata = bus_wdata;
  assign o_fl_wp_n      = ctrl_q[`FESQ_CTRL_WP];

  fesq_bus u_bus (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .bus        (u_bus_if),
    .o_fl_addr  (o_fl_addr),
    .i_fl_dq    (i_fl_dq),
    .o_fl_dq    (o_fl_dq),
    .o_fl_dq_oe (o_fl_dq_oe),
    .o_fl_ce_n  (o_fl_ce_n),
    .o_fl_we_n  (o_fl_we_n),
    .o_fl_oe_n  (o_fl_oe_n)
  );

  // ==================================================================
  // software registers; sticky flags let a set beat a clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      addr_q    <= 21'h000000;
      data_q    <= 16'h0000;
      cnt_q     <= 4'h0;
      bptr_q    <= 4'h0;
      ctrl_q    <= 2'h0;
      done_q    <= 1'b0;
      refused_q <= 1'b0;
      o_rdata   <= 32'h00000000;
      sts_m_q   <= 1'b0;
      sts_s_q   <= 1'b0;
    end else begin
      sts_m_q   <= i_fl_sts;
      sts_s_q   <= sts_m_q;
      o_rdata   <= i_rd ? rd_mux : 32'h00000000;
      if (wr_cfg && i_addr == `FESQ_REG_ADDR) addr_q <= i_wdata[20:0];
      if (wr_cfg && i_addr == `FESQ_REG_DATA) data_q <= i_wdata[15:0];
      if (wr_cfg && i_addr == `FESQ_REG_COUNT) begin
        cnt_q  <= i_wdata[3:0];
        bptr_q <= 4'h0;
      end
      if (wr_cfg && i_addr == `FESQ_REG_BUF) bptr_q <= bptr_q + 4'h1;
      if (wr_cfg && i_addr == `FESQ_REG_CTRL) ctrl_q <= i_wdata[1:0];
      done_q    <= set_done || (done_q && !(wr_stat && i_wdata[`FESQ_ST_DONE]));
      refused_q <= refuse || (refused_q && !(wr_stat && i_wdata[`FESQ_ST_REFUSED]));
    end
  end

  // buffer words kept without reset, loaded by software before use
  always_ff @(posedge i_clk) begin
    if (wr_cfg && i_addr == `FESQ_REG_BUF) begin
      buf_q[bptr_q] <= i_wdata[15:0];
    end
  end

  // ==================================================================
  // command sequencer
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q     <= S_IDLE;
      op_q     <= FESQ_OP_NONE;
      idx_q    <= 4'h0;
      issued_q <= 1'b0;
      fsr_q    <= 8'h00;
      xsr_q    <= 8'h00;
      retry_q  <= 8'h00;
    end else begin
      if (bus_req) issued_q <= 1'b1;
      if (bus_ack) issued_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start && !refuse) begin
            op_q    <= op_in;
            idx_q   <= 4'h0;
            retry_q <= 8'h00;
            st_q    <= (op_in == FESQ_OP_BUF) ? S_XSET : S_W1;
          end
        end
        S_W1: if (bus_ack) begin
          if (op_q == FESQ_OP_CLR) begin
            fsr_q <= 8'h00;
            st_q  <= S_IDLE;
          end else begin
            st_q <= S_W2;
          end
        end
        S_W2: if (bus_ack) st_q <= S_POLL;
        S_XSET: if (bus_ack) st_q <= S_XRD;
        S_XRD: if (bus_ack) begin
          xsr_q <= bus_rdata[7:0];
          if (bus_rdata[`FESQ_XSR_BUF_AVAIL]) begin
            st_q <= S_CNT;
          end else begin
            // setup was ignored by the flash, so it is sent again
            retry_q <= retry_q + 8'h01;
            st_q    <= S_XSET;
          end
        end
        S_CNT: if (bus_ack) st_q <= S_LOAD;
        S_LOAD: if (bus_ack) begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == cnt_q) st_q <= S_CONF;
        end
        S_CONF: if (bus_ack) st_q <= S_POLL;
        S_POLL: if (bus_ack) begin
          // status reads repeat until ready; errors only taken as final then
          fsr_q <= bus_rdata[7:0];
          if (bus_rdata[`FESQ_SR_READY]) st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ==================================================================
  // checks
  AST_ERASE_CONFIRM: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_q == S_W1 && bus_ack && op_q == FESQ_OP_ERASE_BLK) |=>
      (bus_req && st_q == S_W2 && bus_wdata == {8'h00, `FESQ_CMD_CONFIRM} && bus_addr == addr_q))
    else $error("block erase confirm missing");
  AST_CHIP_CONFIRM: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus_req && st_q == S_W1 && op_q == FESQ_OP_ERASE_CHIP) |->
      (bus_wdata == {8'h00, `FESQ_CMD_CHIP_SETUP}) ##[1:30] (bus_req && bus_wdata == {8'h00, `FESQ_CMD_CONFIRM}))
    else $error("chip erase not setup then confirm");
  AST_PROG_DATA: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus_req && st_q == S_W2 && op_q == FESQ_OP_PROG) |-> (bus_wr && bus_wdata == data_q && bus_addr == addr_q))
    else $error("program data write wrong");
  AST_XSR_RETRY: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_q == S_XRD && bus_ack && !bus_rdata[`FESQ_XSR_BUF_AVAIL]) |=>
      (st_q == S_XSET && bus_req && bus_wdata == {8'h00, `FESQ_CMD_BUF_SETUP}))
    else $error("buffer setup not repeated");
  AST_COUNT_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
    (st_q == S_XRD && bus_ack && bus_rdata[`FESQ_XSR_BUF_AVAIL]) |=>
      (bus_req && st_q == S_CNT && bus_wdata == {12'h000, cnt_q}))
    else $error("count write wrong");
  AST_LOAD_RANGE: assert property (@(posedge i_clk) disable iff (i_reset)
    (bus_req && st_q == S_LOAD) |-> (bus_addr >= addr_q && bus_addr <= addr_q + {17'h00000, cnt_q}))
    else $error("buffer address out of range");
  AST_BUF_REFUSE: assert property (@(posedge i_clk) disable iff (i_reset)
    refuse |=> (st_q == S_IDLE && refused_q && !bus_req))
    else $error("buffered program not refused");
  AST_POLL_READY: assert property (@(posedge i_clk) disable iff (i_reset)
    ($rose(done_q) && op_q != FESQ_OP_CLR) |-> $past(poll_ok))
    else $error("done without ready status");
endmodule : fesq_host

// ### dv/fesq_flash_mdl.sv
`timescale 1ns/100ps
module fesq_flash_mdl #(
  parameter int BUSY_NS = 400
) (
  // flash pins
  input  wire logic [20:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_wp_n,
  output logic      [15:0] o_dq,
  output logic             o_status_pin
);
  // ==========================================================
  // device state, knobs poked by the bench
  logic [15:0] mem [int];
  logic [7:0]  status_reg = 8'h80;
  logic [1:0]  mode       = 2'd0;
  logic [2:0]  st         = 3'd0;
  logic [31:0] lock       = '0;
  logic [31:0] bad        = '0;
  logic [31:0] blk_ok     = '0;
  logic        vpp_ok     = 1'b1;
  logic        avail      = 1'b0;
  int          refuse_n   = 0;
  logic [7:0]  last_setup = 8'h00;
  logic [15:0] bd [16];
  logic [20:0] ba [16];
  logic [4:0]  cnt;
  int          n;
  logic [15:0] rd_val;
  logic [15:0] last = 16'h0000;

  function automatic logic [15:0] peek(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction : peek

  // ==========================================================
  // read side
  always @(i_addr, i_oe_n, i_ce_n, mode, status_reg, avail)
    rd_val = mode == 2'd2 ? {8'h00, avail, 7'h00} : mode == 2'd1 ? {8'h00, status_reg} : peek(i_addr);
  // released bus shows the inverse, never a stale value
  always @(posedge i_oe_n) last = rd_val;
  assign o_dq         = (!i_ce_n && !i_oe_n) ? rd_val : ~last;
  assign o_status_pin = status_reg[7];

  // ==========================================================
  // operations
  task automatic busy();
    status_reg[7] = 1'b0;
    fork
      begin
        #(BUSY_NS);
        status_reg[7] = 1'b1;
      end
    join_none
  endtask : busy

  task automatic erase(input logic chip, input logic [20:0] a);
    for (int b = 0; b < 32; b++) begin
      if (chip ? (!lock[b] || i_wp_n) : b == a[19:15]) begin
        if (!chip && lock[b] && !i_wp_n) status_reg = status_reg | 8'h22;
        else if (bad[b]) begin
          // a failing block ends the erase, later blocks stay untouched
          status_reg = status_reg | 8'h20;
          break;
        end else begin
          foreach (mem[k]) if (k[19:15] == b) mem[k] = 16'hFFFF;
          blk_ok[b] = 1'b1;
        end
      end
    end
  endtask : erase

  task automatic prog_buf(input logic [7:0] code);
    if (code != 8'hD0) status_reg = status_reg | 8'h30;
    else if (!vpp_ok) status_reg = status_reg | 8'h18;
    else if (lock[ba[0][19:15]] && !i_wp_n) status_reg = status_reg | 8'h12;
    else for (int i = 0; i <= cnt; i++) begin
      // stop at the first word outside range or block
      if (ba[i] < ba[0] || ba[i] > ba[0] + cnt || ba[i][19:15] != ba[0][19:15]) begin
        status_reg = status_reg | 8'h30;
        break;
      end
      mem[ba[i]] = peek(ba[i]) & bd[i];
    end
  endtask : prog_buf

  // ==========================================================
  // command decoder, data taken at the rising write strobe
  always @(posedge i_we_n) if (!i_ce_n) begin
    case (st)
      3'd0: begin
        mode = 2'd1;
        case (i_dq[7:0])
          8'h20: st = 3'd1;
          8'h30: st = 3'd2;
          8'h40, 8'h10: begin
            st         = 3'd3;
            last_setup = i_dq[7:0];
          end
          8'hE8: begin
            avail = refuse_n == 0 && !(status_reg[4] | status_reg[5]);
            if (refuse_n > 0) refuse_n--;
            mode = 2'd2;
            st   = avail ? 3'd4 : 3'd0;
          end
          8'h50: status_reg[5:1] = 5'h00;
          8'hD0: status_reg = status_reg | 8'h30;
          default: mode = 2'd0;
        endcase
      end
      3'd1, 3'd2: begin
        if (i_dq[7:0] != 8'hD0) status_reg = status_reg | 8'h30;
        else if (!vpp_ok) status_reg = status_reg | 8'h28;
        else erase(st == 3'd2, i_addr);
        st = 3'd0;
        busy();
      end
      3'd3: begin
        if (!vpp_ok) status_reg = status_reg | 8'h18;
        else if (lock[i_addr[19:15]] && !i_wp_n) status_reg = status_reg | 8'h12;
        else mem[i_addr] = peek(i_addr) & i_dq;
        st = 3'd0;
        busy();
      end
      3'd4: begin
        cnt  = i_dq[4:0];
        n    = 0;
        mode = 2'd1;
        if (cnt > 5'h0F) status_reg = status_reg | 8'h30;
        st = cnt > 5'h0F ? 3'd0 : 3'd5;
      end
      3'd5: begin
        bd[n] = i_dq;
        ba[n] = i_addr;
        n++;
        if (n > cnt) st = 3'd6;
      end
      default: begin
        prog_buf(i_dq[7:0]);
        st = 3'd0;
        busy();
      end
    endcase
  end
endmodule : fesq_flash_mdl

// ### dv/fesq_host_test.sv
`timescale 1ns/100ps
`include "fesq_map.svh"
module fesq_host_test;
  // ==========================================================
  // stimulus and wiring
  logic        i_clk   = 1'b0;
  logic        i_reset = 1'b1;
  logic [4:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [31:0] o_rdata;
  logic [31:0] s;
  logic [20:0] o_fl_addr;
  logic [15:0] o_fl_dq;
  logic [15:0] mdl_dq;
  logic        o_fl_dq_oe, o_fl_ce_n, o_fl_we_n, o_fl_oe_n, o_fl_wp_n, status_pin;
  wire  [15:0] dq_w = o_fl_dq_oe ? o_fl_dq : mdl_dq;
  int          errors     = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  // {vpp ok, lock, wp level, op, expected status}
  logic [13:0] tv [7] = '{14'h0B98, 14'h3392, 14'h09A8, 14'h31A2, 14'h0AA8, 14'h3980, 14'h3280};

  always #10 i_clk = ~i_clk;

  fesq_host u_dut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fl_addr,
                   .i_fl_dq(dq_w), .o_fl_dq, .o_fl_dq_oe, .o_fl_ce_n, .o_fl_we_n, .o_fl_oe_n,
                   .o_fl_wp_n, .i_fl_sts(status_pin));
  fesq_flash_mdl u_flash (.i_addr(o_fl_addr), .i_dq(dq_w), .i_ce_n(o_fl_ce_n), .i_we_n(o_fl_we_n),
                          .i_oe_n(o_fl_oe_n), .i_wp_n(o_fl_wp_n), .o_dq(mdl_dq), .o_status_pin(status_pin));

  // ==========================================================
  // access tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask : rd

  // polls stays bounded at 500 reads; a hang ends in a failed done check instead
  task automatic op(input logic [2:0] c);
    wr(`FESQ_REG_CMD, {29'h0, c});
    for (int i = 0; i < 500; i++) begin
      rd(`FESQ_REG_STAT, s);
      if (s[16] === 1'b1) break;
    end
    chk({s[18], s[16]}, 2'b11);
    wr(`FESQ_REG_STAT, 32'h10000);
  endtask : op

  task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic [7:0] e);
    wr(`FESQ_REG_ADDR, {11'h0, a});
    wr(`FESQ_REG_DATA, {16'h0, d});
    op(3'd3);
    chk(s[7:0], e);
  endtask : prog

  task automatic buf_prog(input logic [20:0] a, input logic [3:0] c, input logic [7:0] e);
    wr(`FESQ_REG_COUNT, {28'h0, c});
    for (int i = 0; i <= c; i++) wr(`FESQ_REG_BUF, 32'hA000 + i);
    wr(`FESQ_REG_ADDR, {11'h0, a});
    op(3'd4);
    chk(s[7:0], e);
  endtask : buf_prog

  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // watchdog, far above the expected run length
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    chk({o_fl_ce_n, o_fl_we_n, o_fl_oe_n, o_fl_dq_oe}, 4'hE);
    wr(`FESQ_REG_CTRL, 32'h1);
    prog(21'h100, 16'h1234, 8'h80);
    chk(u_flash.peek(32'h100), 16'h1234);
    wr(`FESQ_REG_CTRL, 32'h3);
    prog(21'h8100, 16'h5A5A, 8'h80);
    chk(u_flash.last_setup, 8'h10);
    for (int k = 0; k < 7; k++) begin
      u_flash.vpp_ok = tv[k][13];
      u_flash.lock   = {32{tv[k][12]}};
      wr(`FESQ_REG_CTRL, {31'h0, tv[k][11]});
      wr(`FESQ_REG_ADDR, 32'h100);
      op(tv[k][10:8]);
      chk(s[7:0], tv[k][7:0]);
      if (k == 4) chk(u_flash.peek(32'h100), 16'h1234);
      op(3'd5);
      chk(s[5:1], 5'h00);
    end
    chk(u_flash.peek(32'h100), 16'hFFFF);
    chk(u_flash.peek(32'h8100), 16'h5A5A);
    u_flash.lock   = '0;
    u_flash.bad    = 32'h00000002;
    op(3'd2);
    chk(s[7:0], 8'hA0);
    chk(u_flash.blk_ok[2:0], 3'b001);
    chk(u_flash.peek(32'h8100), 16'h5A5A);
    op(3'd5);
    u_flash.bad    = '0;
    u_flash.vpp_ok = 1'b0;
    prog(21'h300, 16'h0000, 8'h98);
    u_flash.vpp_ok = 1'b1;
    prog(21'h300, 16'h0000, 8'h98);
    wr(`FESQ_REG_CMD, 32'h4);
    rd(`FESQ_REG_STAT, s);
    chk(s[17], 1'b1);
    wr(`FESQ_REG_CMD, 32'h6);
    rd(`FESQ_REG_CMD, s);
    chk(s[3:0], 4'h3);
    wr(`FESQ_REG_STAT, 32'h20000);
    op(3'd5);
    u_flash.refuse_n = 2;
    buf_prog(21'h200, 4'd3, 8'h80);
    rd(`FESQ_REG_COUNT, s);
    chk(s[15:8], 8'h02);
    for (int i = 0; i < 4; i++) chk(u_flash.peek(32'h200 + i), 16'hA000 + i);
    buf_prog(21'h7FF8, 4'd15, 8'hB0);
    chk(u_flash.peek(32'h7FFF), 16'hA007);
    chk(u_flash.peek(32'h8000), 16'hFFFF);
    tally_and_finish();
  end
endmodule : fesq_host_test
